// ---- src/icf_consts.vh ----
// Purpose: Shared constants of the input conditioning filter
// Assumes: Included by bare name from every design file
// Notes:   Byte offsets on a 32-bit Avalon-MM slave, one word per register
`ifndef ICF_CONSTS_VH
`define ICF_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ICF_ADDR_W         6
`define ICF_OFS_CTRL       6'h00
`define ICF_OFS_IN_MASK    6'h04
`define ICF_OFS_OUT_MASK   6'h08
`define ICF_OFS_IN_POL     6'h0c
`define ICF_OFS_OUT_POL    6'h10
`define ICF_OFS_GP_OUT     6'h14
`define ICF_OFS_IN_LEVEL   6'h18
`define ICF_OFS_FILT_OUT   6'h1c
`define ICF_OFS_SAMPLE     6'h20

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define ICF_SET_W          5
`define ICF_SET_MSB        4
`define ICF_CLR_BIT        8
`define ICF_N_IN           6
`define ICF_N_OUT          2
`define ICF_ADC_W          12
`define ICF_FRAC_W         16
`define ICF_AVG_DEPTH      16

// ****************************************************************
// Reset values and filter codes
// ****************************************************************
`define ICF_SET_RESET      5'h00
`define ICF_SET_AVG_MAX    5'h10
`define ICF_SET_REC_BASE   5'h10
`define ICF_MASK_RESET     6'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ICF_CLK_PERIOD_NS  10
`define ICF_TICK_TIME_NS   1000000
`define ICF_TICK_CYCLES    (`ICF_TICK_TIME_NS / `ICF_CLK_PERIOD_NS)

`endif

// ---- src/icf_tick.v ----
// Purpose: Millisecond sample tick from the system clock
// Assumes: Clock period as in the constants header
// Notes:   One-cycle pulse every TICK_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
`include "icf_consts.vh"

module icf_tick #(
  parameter integer TICK_CYCLES = `ICF_TICK_CYCLES
) (
  input  wire clk_i,
  input  wire rst_n_i,
  output reg  tick_o
);

  reg [16:0] cnt;

  // ****************************************************************
  // Divider
  // ****************************************************************
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 17'h00000;
      tick_o <= 1'b0;
    end else if (cnt == TICK_CYCLES[16:0] - 17'h00001) begin
      cnt    <= 17'h00000;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 17'h00001;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- src/icf_filt.v ----
// Purpose: Moving average or first-order recursive low-pass of samples
// Assumes: tick_i marks one new sample per millisecond
// Notes:   Result updates one clock after each tick
`timescale 1ns/1ps
`default_nettype none
`include "icf_consts.vh"

module icf_filt (
  input  wire                           clk_i,
  input  wire                           rst_n_i,
  input  wire                           tick_i,
  input  wire                           clr_i,
  input  wire [`ICF_SET_MSB:0]          set_i,
  input  wire signed [`ICF_ADC_W-1:0]   x_i,
  output reg  signed [`ICF_ADC_W-1:0]   y_o
);

  localparam AW = `ICF_ADC_W + `ICF_FRAC_W;

  reg  signed [`ICF_ADC_W-1:0] hist [0:`ICF_AVG_DEPTH-1];
  reg  signed [AW-1:0]         acc;
  reg  signed [AW-1:0]         next_acc;
  reg  signed [`ICF_ADC_W+4:0] sum;
  reg  signed [`ICF_ADC_W+4:0] avg;
  wire [3:0]                   shift;
  wire signed [AW-1:0]         x_ext;
  wire                         is_rec;
  integer                      i;
  genvar                       g;

  assign is_rec = (set_i > `ICF_SET_AVG_MAX);
  assign shift  = set_i[3:0];
  assign x_ext  = {x_i, {`ICF_FRAC_W{1'b0}}};

  // ****************************************************************
  // Sample history, one shift stage per entry
  // ****************************************************************
  generate
    for (g = 0; g < `ICF_AVG_DEPTH; g = g + 1) begin : g_hist
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          hist[g] <= {`ICF_ADC_W{1'b0}};
        end else if (clr_i) begin
          hist[g] <= {`ICF_ADC_W{1'b0}};
        end else if (tick_i) begin
          hist[g] <= (g == 0) ? x_i : hist[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // Average over the newest set_i entries
  always @* begin
    sum = {(`ICF_ADC_W+5){1'b0}};
    for (i = 0; i < `ICF_AVG_DEPTH; i = i + 1) begin
      if (i < set_i)
        sum = sum + {{5{hist[i][`ICF_ADC_W-1]}}, hist[i]};
    end
    if (set_i <= 5'h01)
      avg = {{5{hist[0][`ICF_ADC_W-1]}}, hist[0]};       // [R9]
    else
      avg = sum / $signed({12'h000, set_i});              // [R9]
  end

  // Recursive step, gain of one half per setting step
  always @* begin
    next_acc = acc + ((x_ext - acc) >>> shift);            // [R10] [R1]
  end

  // ****************************************************************
  // Accumulator and output
  // ****************************************************************
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= {AW{1'b0}};
      y_o <= {`ICF_ADC_W{1'b0}};
    end else if (clr_i) begin
      acc <= {AW{1'b0}};
      y_o <= {`ICF_ADC_W{1'b0}};
    end else if (tick_i) begin
      acc <= is_rec ? next_acc : x_ext;                    // [R2] [R3]
    end else if (is_rec) begin
      y_o <= acc[AW-1:`ICF_FRAC_W] + {{(`ICF_ADC_W-1){1'b0}}, acc[`ICF_FRAC_W-1]}; // [R3]
    end else begin
      y_o <= avg[`ICF_ADC_W-1:0];                          // [R9]
    end
  end

endmodule
`default_nettype wire

// ---- src/icf_top.v ----
// Purpose: Input conditioning for a stepper controller: analogue filter,
//          digital input and output masking, edge polarity, register access
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes:   Summary of the behaviour follows
//
// Summary of operation
// R1: Recursive settings 17..31 give time constant 1 ms doubling up to 16 s; the code gives about 1.4 ms doubling up to about 33 s.
// R2: After a step the recursive output reaches 99.9 percent within ten constants.
// R3: Full-scale step leaves at most one converter code after ten constants.
// R4: Masked inputs and outputs are ignored by control logic, free for general use.
// R5: Masked inputs drop out of record selection and count as zero.
// R6: Levels of masked inputs are readable by the host over the bus.
// R7: Every input and output has its own rising or falling edge choice.
// R8: Analogue input is sampled each millisecond, feeding the selected filter.
// R9: Settings 0..16 average that many newest samples; 0 and 1 pass through.
// R10: Settings 17 and above select a first-order recursive low-pass.
// R11: Filter setting is a five-bit code 0..31, resetting to 0.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "icf_consts.vh"

module icf_top #(
  parameter integer TICK_CYCLES = `ICF_TICK_CYCLES
) (
  input  wire                         CLOCK_I,
  input  wire                         RST_N_I,
  // Avalon-MM slave
  input  wire [`ICF_ADDR_W-1:0]       AVS_ADDRESS_I,
  input  wire                         AVS_READ_I,
  input  wire                         AVS_WRITE_I,
  input  wire [31:0]                  AVS_WRITEDATA_I,
  input  wire [3:0]                   AVS_BYTEENABLE_I,
  output reg  [31:0]                  AVS_READDATA_O,
  output reg                          AVS_WAITREQUEST_O,
  // Converter and digital lines
  input  wire [`ICF_ADC_W-1:0]        ADC_DATA_I,
  input  wire [`ICF_N_IN-1:0]         IN_PIN_I,
  input  wire [`ICF_N_OUT-1:0]        DRV_OUT_I,
  output reg  [`ICF_N_OUT-1:0]        OUT_PIN_O,
  // Towards the driver control logic
  output reg  [`ICF_ADC_W-1:0]        FILT_OUT_O,
  output reg                          FILT_VALID_O,
  output reg  [`ICF_N_IN-1:0]         IN_ACTIVE_O,
  output reg  [`ICF_N_IN-1:0]         IN_EVENT_O,
  output reg  [`ICF_N_IN-1:0]         REC_SEL_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [`ICF_SET_MSB:0]        filt_set;
  reg  [`ICF_N_IN-1:0]         in_mask;
  reg  [`ICF_N_OUT-1:0]        out_mask;
  reg  [`ICF_N_IN-1:0]         in_pol;
  reg  [`ICF_N_OUT-1:0]        out_pol;
  reg  [`ICF_N_OUT-1:0]        gp_out;
  reg                          filt_clr;
  reg  [`ICF_ADC_W-1:0]        adc_s1;
  reg  [`ICF_ADC_W-1:0]        adc_s2;
  reg  [`ICF_ADC_W-1:0]        sample;
  reg  [`ICF_N_IN-1:0]         in_s1;
  reg  [`ICF_N_IN-1:0]         in_s2;
  reg  [`ICF_N_IN-1:0]         in_prev;
  reg  [`ICF_N_OUT-1:0]        drv_prev;
  reg                          tick_d;
  reg                          tick_d2;
  reg                          tick_d3;
  reg  [31:0]                  next_rdata;
  reg  [`ICF_N_IN-1:0]         next_active;
  reg  [`ICF_N_IN-1:0]         next_event;
  reg  [`ICF_N_OUT-1:0]        next_out;
  wire                         tick;
  wire [`ICF_ADC_W-1:0]        filt_y;
  wire                         req;
  wire                         wr_go;
  integer                      k;

  assign req   = AVS_READ_I | AVS_WRITE_I;
  assign wr_go = AVS_WRITE_I & ~AVS_WAITREQUEST_O;

  // ****************************************************************
  // Millisecond tick and filter
  // ****************************************************************
  icf_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .tick_o  (tick)
  );

  icf_filt u_filt (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .tick_i  (tick_d),
    .clr_i   (filt_clr),
    .set_i   (filt_set),
    .x_i     (sample),
    .y_o     (filt_y)
  );

  // ****************************************************************
  // Input synchronisers and sample capture
  // ****************************************************************
  // Two stages for converter word and digital lines
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      adc_s1 <= {`ICF_ADC_W{1'b0}};
      adc_s2 <= {`ICF_ADC_W{1'b0}};
      in_s1  <= {`ICF_N_IN{1'b0}};
      in_s2  <= {`ICF_N_IN{1'b0}};
    end else begin
      adc_s1 <= ADC_DATA_I;
      adc_s2 <= adc_s1;
      in_s1  <= IN_PIN_I;
      in_s2  <= in_s1;
    end
  end

  // Take one converter sample per tick
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sample  <= {`ICF_ADC_W{1'b0}};
      tick_d  <= 1'b0;
      tick_d2 <= 1'b0;
      tick_d3 <= 1'b0;
    end else begin
      tick_d  <= tick;
      // Strobe follows the two stages between filter update and output port
      tick_d2 <= tick_d;
      tick_d3 <= tick_d2;
      if (tick)
        sample <= adc_s2;                                  // [R8]
    end
  end

  // Filter result towards control logic, valid after each update
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FILT_OUT_O   <= {`ICF_ADC_W{1'b0}};
      FILT_VALID_O <= 1'b0;
    end else begin
      FILT_OUT_O   <= filt_y;
      FILT_VALID_O <= tick_d3;                             // [R8]
    end
  end

  // ****************************************************************
  // Digital inputs: polarity, masking, edge events
  // ****************************************************************
  // Active level follows polarity; masked lines read as zero
  always @* begin
    next_active = {`ICF_N_IN{1'b0}};
    next_event  = {`ICF_N_IN{1'b0}};
    for (k = 0; k < `ICF_N_IN; k = k + 1) begin
      next_active[k] = ~in_mask[k] & (in_s2[k] ^ in_pol[k]);           // [R4] [R7]
      if (!in_mask[k]) begin
        if (in_pol[k])
          next_event[k] = in_prev[k] & ~in_s2[k];                      // [R7]
        else
          next_event[k] = ~in_prev[k] & in_s2[k];                      // [R7]
      end
    end
  end

  // Registered input outputs
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_prev     <= {`ICF_N_IN{1'b0}};
      IN_ACTIVE_O <= {`ICF_N_IN{1'b0}};
      IN_EVENT_O  <= {`ICF_N_IN{1'b0}};
      REC_SEL_O   <= {`ICF_N_IN{1'b0}};
    end else begin
      in_prev     <= in_s2;
      IN_ACTIVE_O <= next_active;                                       // [R4]
      IN_EVENT_O  <= next_event;                                        // [R4]
      REC_SEL_O   <= next_active & ~in_mask;                            // [R5]
    end
  end

  // ****************************************************************
  // Digital outputs: driver request or general-purpose value
  // ****************************************************************
  // Falling polarity drives the line low when active
  always @* begin
    next_out = {`ICF_N_OUT{1'b0}};
    for (k = 0; k < `ICF_N_OUT; k = k + 1) begin
      if (out_mask[k])
        next_out[k] = gp_out[k];                                        // [R4]
      else
        next_out[k] = DRV_OUT_I[k] ^ out_pol[k];                        // [R7]
    end
  end

  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUT_PIN_O <= {`ICF_N_OUT{1'b0}};
      drv_prev  <= {`ICF_N_OUT{1'b0}};
    end else begin
      OUT_PIN_O <= next_out;
      drv_prev  <= DRV_OUT_I;
    end
  end

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  always @* begin
    next_rdata = 32'h00000000;
    case (AVS_ADDRESS_I)
      `ICF_OFS_CTRL:     next_rdata[`ICF_SET_MSB:0] = filt_set;
      `ICF_OFS_IN_MASK:  next_rdata[`ICF_N_IN-1:0]  = in_mask;
      `ICF_OFS_OUT_MASK: next_rdata[`ICF_N_OUT-1:0] = out_mask;
      `ICF_OFS_IN_POL:   next_rdata[`ICF_N_IN-1:0]  = in_pol;
      `ICF_OFS_OUT_POL:  next_rdata[`ICF_N_OUT-1:0] = out_pol;
      `ICF_OFS_GP_OUT:   next_rdata[`ICF_N_OUT-1:0] = gp_out;
      `ICF_OFS_IN_LEVEL: next_rdata[`ICF_N_IN-1:0]  = in_s2 & in_mask;  // [R6]
      `ICF_OFS_FILT_OUT: next_rdata = {{(32-`ICF_ADC_W){filt_y[`ICF_ADC_W-1]}}, filt_y};
      `ICF_OFS_SAMPLE:   next_rdata = {{(32-`ICF_ADC_W){sample[`ICF_ADC_W-1]}}, sample};
      default:           next_rdata = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Bus handshake: wait one cycle, then answer
  // ****************************************************************
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h00000000;
    end else if (req && AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O    <= AVS_READ_I ? next_rdata : 32'h00000000;
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  // ****************************************************************
  // Register writes, taken when waitrequest is low
  // ****************************************************************
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      filt_set <= `ICF_SET_RESET;                                       // [R11]
      filt_clr <= 1'b0;
      in_mask  <= `ICF_MASK_RESET;
      out_mask <= {`ICF_N_OUT{1'b0}};
      in_pol   <= {`ICF_N_IN{1'b0}};
      out_pol  <= {`ICF_N_OUT{1'b0}};
      gp_out   <= {`ICF_N_OUT{1'b0}};
    end else begin
      filt_clr <= 1'b0;
      if (wr_go && AVS_BYTEENABLE_I[0]) begin
        case (AVS_ADDRESS_I)
          `ICF_OFS_CTRL:     filt_set <= AVS_WRITEDATA_I[`ICF_SET_MSB:0]; // [R11]
          `ICF_OFS_IN_MASK:  in_mask  <= AVS_WRITEDATA_I[`ICF_N_IN-1:0];  // [R4]
          `ICF_OFS_OUT_MASK: out_mask <= AVS_WRITEDATA_I[`ICF_N_OUT-1:0]; // [R4]
          `ICF_OFS_IN_POL:   in_pol   <= AVS_WRITEDATA_I[`ICF_N_IN-1:0];  // [R7]
          `ICF_OFS_OUT_POL:  out_pol  <= AVS_WRITEDATA_I[`ICF_N_OUT-1:0]; // [R7]
          `ICF_OFS_GP_OUT:   gp_out   <= AVS_WRITEDATA_I[`ICF_N_OUT-1:0];
          default:           gp_out   <= gp_out;
        endcase
      end
      // Clear filter history, byte lane 1
      if (wr_go && AVS_BYTEENABLE_I[1] && AVS_ADDRESS_I == `ICF_OFS_CTRL)
        filt_clr <= AVS_WRITEDATA_I[`ICF_CLR_BIT];
    end
  end

endmodule
`default_nettype wire

// ---- verif/icf_top_asserts.sv ----
// Purpose: Port-level checks of the input conditioning block
// Assumes: Same tick parameter as the top instance
// Notes:   Bound into icf_top below the module
`timescale 1ns/1ps
`default_nettype none
`include "icf_consts.vh"
module icf_chk #(
  parameter integer TICK_CYCLES = 20
) (
  input wire logic                   CLOCK_I,
  input wire logic                   RST_N_I,
  input wire logic                   AVS_READ_I,
  input wire logic                   AVS_WRITE_I,
  input wire logic [31:0]            AVS_READDATA_O,
  input wire logic                   AVS_WAITREQUEST_O,
  input wire logic [`ICF_N_OUT-1:0]  DRV_OUT_I,
  input wire logic [`ICF_N_OUT-1:0]  OUT_PIN_O,
  input wire logic [`ICF_ADC_W-1:0]  FILT_OUT_O,
  input wire logic                   FILT_VALID_O,
  input wire logic [`ICF_N_IN-1:0]   IN_ACTIVE_O,
  input wire logic [`ICF_N_IN-1:0]   IN_EVENT_O
);
  // ****
  // Helper counters
  // ****
  integer                  gap;
  logic                    seen;
  logic [1:0]              quiet;
  logic [`ICF_N_OUT-1:0]   drv_q;
  // Cycles since last result, cycles since last cause of an output change
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gap   <= 0;
      seen  <= 1'b0;
      quiet <= 2'h0;
      drv_q <= '0;
    end else begin
      gap   <= FILT_VALID_O ? 0 : gap + 1;
      seen  <= seen | FILT_VALID_O;
      drv_q <= DRV_OUT_I;
      if (DRV_OUT_I != drv_q || (AVS_WRITE_I && !AVS_WAITREQUEST_O)) begin
        quiet <= 2'h0;
      end else if (quiet != 2'h3) begin
        quiet <= quiet + 2'h1;
      end
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  wait_answer_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("request not answered next cycle");
  wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  wait_cause_a: assert property (!AVS_WAITREQUEST_O |-> $past(AVS_READ_I || AVS_WRITE_I))
    else $error("answer without request");
  rdata_hold_a: assert property ($changed(AVS_READDATA_O) |-> !AVS_WAITREQUEST_O)
    else $error("read data moved outside answer");
  valid_single_a: assert property (FILT_VALID_O |=> !FILT_VALID_O)
    else $error("result strobe longer than one cycle");
  valid_period_a: assert property (FILT_VALID_O && seen |-> gap == TICK_CYCLES - 1)
    else $error("result spacing not one tick");
  event_pulse_a: assert property ((IN_EVENT_O & $past(IN_EVENT_O)) == '0)
    else $error("edge event longer than one cycle");
  event_level_a: assert property (IN_EVENT_O != '0 |-> ##[0:1] IN_ACTIVE_O != '0)
    else $error("edge event without active input");
  out_cause_a: assert property ($changed(OUT_PIN_O) |-> quiet != 2'h3)
    else $error("output line moved without cause");
  filt_hold_a: assert property ($changed(FILT_OUT_O)
    |-> FILT_VALID_O || $past(FILT_VALID_O) || quiet != 2'h3)
    else $error("filter output moved between samples");
  result_c: cover property (FILT_VALID_O ##1 !FILT_VALID_O);
  answer_c: cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
  event_c: cover property (IN_EVENT_O != '0);
endmodule
bind icf_top icf_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .CLOCK_I           (CLOCK_I),
  .RST_N_I           (RST_N_I),
  .AVS_READ_I        (AVS_READ_I),
  .AVS_WRITE_I       (AVS_WRITE_I),
  .AVS_READDATA_O    (AVS_READDATA_O),
  .AVS_WAITREQUEST_O (AVS_WAITREQUEST_O),
  .DRV_OUT_I         (DRV_OUT_I),
  .OUT_PIN_O         (OUT_PIN_O),
  .FILT_OUT_O        (FILT_OUT_O),
  .FILT_VALID_O      (FILT_VALID_O),
  .IN_ACTIVE_O       (IN_ACTIVE_O),
  .IN_EVENT_O        (IN_EVENT_O)
);
`default_nettype wire

// ---- verif/icf_line_model.sv ----
// Purpose: Converter and digital input lines feeding the block
// Assumes: Bench commands code, levels and settling lag
// Notes:   Converter output settles lag_i + 1 clocks after a new code
`timescale 1ns/1ps
`default_nettype none
`include "icf_consts.vh"
module icf_line_model (
  input  wire logic                  clk_i,
  input  wire logic [`ICF_ADC_W-1:0] code_i,
  input  wire logic [`ICF_N_IN-1:0]  lvl_i,
  input  wire logic [3:0]            lag_i,
  output var  logic [`ICF_ADC_W-1:0] adc_o,
  output var  logic [`ICF_N_IN-1:0]  pin_o
);
  logic [3:0] cnt;
  initial begin
    adc_o = '0;
    pin_o = '0;
    cnt   = 4'h0;
  end
  // Lines follow at once, converter waits out its lag
  always @(posedge clk_i) begin
    pin_o <= lvl_i;
    if (code_i == adc_o || cnt >= lag_i) begin
      adc_o <= code_i;
      cnt   <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/icf_top_test.sv ----
// Purpose: Self-checking bench of the input conditioning block
// Assumes: Short tick of 20 clocks stands in for one millisecond
// Notes:   Bus tasks hold each request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
`include "icf_consts.vh"
module icf_top_test;
  localparam integer TK = 20;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, ev_clr = 1'b0;
  logic [5:0]  addr = 6'h00, lvl = 6'h00, ev_seen = 6'h00;
  logic [31:0] wdata = 32'h0, q;
  logic [11:0] code = 12'h000, cv;
  logic [3:0]  lag = 4'h0;
  logic [1:0]  drv = 2'h0;
  wire  logic [31:0] rdata;
  wire  logic [11:0] adc, filt;
  wire  logic [5:0]  pin, act, evt, rsel;
  wire  logic [1:0]  out_pin;
  wire  logic        waitreq, fvalid;
  integer      err_total = 0, total_checks = 0, i;
  icf_line_model lines (.clk_i(clk), .code_i(code), .lvl_i(lvl), .lag_i(lag),
    .adc_o(adc), .pin_o(pin));
  icf_top #(.TICK_CYCLES(TK)) uut (.CLOCK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .ADC_DATA_I(adc), .IN_PIN_I(pin),
    .DRV_OUT_I(drv), .OUT_PIN_O(out_pin), .FILT_OUT_O(filt), .FILT_VALID_O(fvalid),
    .IN_ACTIVE_O(act), .IN_EVENT_O(evt), .REC_SEL_O(rsel));
  // ****
  // Clock, event capture, tasks
  // ****
  always #5 clk = ~clk;
  always @(posedge clk) ev_seen <= ev_clr ? 6'h00 : (ev_seen | evt);
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      addr <= a; wdata <= d; rd <= !w; wr <= w;
      @(negedge clk);
      while (waitreq !== 1'b0 && n < 50) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 50) err_total = err_total + 1;
      @(posedge clk);
      q = rdata;
      rd <= 1'b0; wr <= 1'b0;
    end
  endtask
  task automatic put(input logic [11:0] c, input logic [5:0] l, input logic [1:0] d,
                     input logic [3:0] g);
    begin
      @(posedge clk);
      code <= c; lvl <= l; drv <= d; lag <= g; ev_clr <= 1'b1;
      @(posedge clk);
      ev_clr <= 1'b0;
    end
  endtask
  task automatic stay(input integer k);
    repeat (k) @(negedge clk);
  endtask
  task automatic tk(input integer k);
    integer n;
    repeat (k) begin
      n = 0;
      @(negedge clk);
      while (fvalid !== 1'b1 && n < 4 * TK) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 4 * TK) err_total = err_total + 1;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input integer lo, input integer hi, input logic [11:0] g);
    total_checks = total_checks + 1;
    if ((^g === 1'bx) || $signed(g) < lo || $signed(g) > hi) begin
      err_total = err_total + 1;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, $signed(g));
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    err_total = err_total + 1;
    tally_and_finish();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, `ICF_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    bus(1'b1, `ICF_OFS_CTRL, 32'h3f);
    bus(1'b0, `ICF_OFS_CTRL, 32'h0);
    chk("ctrl width", 32'h1f, q);
    bus(1'b1, 6'h24, 32'h5a);
    bus(1'b0, 6'h24, 32'h0);
    chk("unmapped", 32'h0, q);
    // Settings 0 and 1 pass samples straight through
    for (i = 0; i < 2; i = i + 1) begin
      cv = (i == 0) ? 12'h123 : 12'hf00;
      put(cv, 6'h00, 2'h0, 4'h0);
      bus(1'b1, `ICF_OFS_CTRL, i);
      tk(3);
      chk("thru", {20'h0, cv}, {20'h0, filt});
      bus(1'b0, `ICF_OFS_SAMPLE, 32'h0);
      chk("sample", {{20{cv[11]}}, cv}, q);
    end
    // Sixteen-point average from a cleared history, slow converter
    put(12'h040, 6'h00, 2'h0, 4'h9);
    tk(2);
    bus(1'b1, `ICF_OFS_CTRL, 32'h110);
    tk(8);
    rng("avg part", 28, 36, filt);
    tk(10);
    rng("avg full", 64, 64, filt);
    // Full-range step through the fastest recursive setting
    put(12'h800, 6'h00, 2'h0, 4'h9);
    bus(1'b1, `ICF_OFS_CTRL, 32'h111);
    tk(20);
    rng("rec low", -2048, -2047, filt);
    put(12'h7ff, 6'h00, 2'h0, 4'h9);
    tk(11);
    rng("rec 10T", 2043, 2047, filt);
    tk(4);
    rng("rec lsb", 2046, 2047, filt);
    // Setting 21 should be near 40 percent after 16 samples
    put(12'h3e8, 6'h00, 2'h0, 4'h0);
    tk(1);
    bus(1'b1, `ICF_OFS_CTRL, 32'h115);
    tk(16);
    rng("rec T16", 300, 560, filt);
    // Input masking and polarity
    put(12'h000, 6'h05, 2'h0, 4'h0);
    stay(6);
    chk("active", 32'h05, {26'h0, act});
    chk("recsel", 32'h05, {26'h0, rsel});
    bus(1'b1, `ICF_OFS_IN_MASK, 32'h03);
    bus(1'b1, `ICF_OFS_IN_POL, 32'h38);
    stay(4);
    chk("act mask", 32'h3c, {26'h0, act});
    chk("rsel mask", 32'h3c, {26'h0, rsel});
    bus(1'b0, `ICF_OFS_IN_LEVEL, 32'h0);
    chk("in level", 32'h01, q);
    bus(1'b1, `ICF_OFS_IN_POL, 32'h02);
    bus(1'b1, `ICF_OFS_IN_MASK, 32'h04);
    put(12'h000, 6'h00, 2'h0, 4'h0);
    stay(6);
    put(12'h000, 6'h07, 2'h0, 4'h0);
    stay(6);
    chk("ev rise", 32'h01, {26'h0, ev_seen});
    put(12'h000, 6'h00, 2'h0, 4'h0);
    stay(6);
    chk("ev fall", 32'h02, {26'h0, ev_seen});
    // Output polarity and masking
    put(12'h000, 6'h00, 2'h1, 4'h0);
    stay(3);
    chk("out drv", 32'h1, {30'h0, out_pin});
    bus(1'b1, `ICF_OFS_OUT_POL, 32'h2);
    stay(3);
    chk("out pol", 32'h3, {30'h0, out_pin});
    bus(1'b1, `ICF_OFS_OUT_MASK, 32'h1);
    stay(3);
    chk("out mask", 32'h2, {30'h0, out_pin});
    put(12'h000, 6'h00, 2'h3, 4'h0);
    stay(3);
    chk("out held", 32'h0, {30'h0, out_pin});
    bus(1'b1, `ICF_OFS_GP_OUT, 32'h3);
    stay(3);
    chk("gp out", 32'h1, {30'h0, out_pin});
    tally_and_finish();
  end
endmodule
`default_nettype wire
